// ### hw/ofp_pkg.sv
// Shared constants, types and decode for the output fault protection block
package ofp_pkg;

  localparam int CH_COUNT_DEF = 2;
  localparam int ADDR_W       = 8;
  localparam int DATA_W       = 32;

  // Register byte offsets, one aligned word each
  localparam logic [ADDR_W-1:0] CFG_BASE_OFS      = 8'h00;
  localparam logic [ADDR_W-1:0] CFG_STRIDE        = 8'h04;
  localparam logic [ADDR_W-1:0] CHANNEL_FAULT_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFS      = 8'h0C;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS      = 8'h10;
  localparam logic [ADDR_W-1:0] CTRL_OFS          = 8'h14;

  // Channel configuration word
  localparam int CFG_THR_LSB   = 0;
  localparam int THR_W         = 4;
  localparam int CFG_OVLAT_BIT = 4;

  // Fault nibble per channel, channel n at bit 4*n
  localparam int FLT_OV    = 0;
  localparam int FLT_OC    = 1;
  localparam int FLT_OL    = 2;
  localparam int FLT_SHORT = 3;
  localparam int FLT_W     = 4;

  // Reset values
  localparam logic [THR_W-1:0] THR_RESET   = 4'h2;
  localparam logic             OVLAT_RESET = 1'b0;

  // Consecutive-cycle filter lengths
  localparam int SHORT_FILT_CYC = 8;
  localparam int BOOST_FILT_CYC = 2;
  localparam int OL_FILT_CYC    = 8;

  // Short threshold scale, millivolts
  localparam int THR_MV_W                  = 10;
  localparam logic [THR_MV_W-1:0] STEP_MV  = 10'h02D;
  localparam logic [THR_MV_W-1:0] CODE0_MV = 10'h2D6;

  // Comparator results of one channel, all from the analog front end
  typedef struct packed {
    logic fb_below_short;
    logic fb_above_ov;
    logic fb_below_ov_hys;
    logic sns_above_oc_rise;
    logic sns_below_oc_fall;
    logic fb_above_ol;
    logic sns_below_ol;
    logic sns_above_short;
    logic sns_high_low;
    logic ss_released;
  } ofp_cmp_t;

  localparam int CMP_W = $bits(ofp_cmp_t);

  // Code n selects n steps; code 0 is the top step
  function automatic logic [THR_MV_W-1:0] ofp_short_th_mv(input logic [THR_W-1:0] code);
    logic [THR_MV_W-1:0] v;
    v = STEP_MV * THR_MV_W'(code);
    if (code == '0) begin
      v = CODE0_MV;
    end
    return v;
  endfunction

endpackage

// ### hw/ofp_sync.sv
// Two-stage synchroniser for comparator and pin levels
`timescale 1ns/1ps
module ofp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;
endmodule

// ### hw/ofp_filter.sv
// Consecutive-cycle qualifier: output high once input held LEN cycles
`timescale 1ns/1ps
module ofp_filter #(
  parameter int LEN = 8
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  localparam int CW = $clog2(LEN + 1);
  localparam logic [CW-1:0] LEN_C = CW'(LEN);

  logic [CW-1:0] cnt_reg;

  // Any low cycle restarts the count
  always_ff @(posedge clk) begin
    if (rst || !din) begin
      cnt_reg <= '0;
    end else if (cnt_reg != LEN_C) begin
      cnt_reg <= cnt_reg + CW'(1);
    end
  end

  assign dout = din && (cnt_reg == LEN_C);
endmodule

// ### hw/ofp_top.sv
// Output fault protection for a multi-channel LED converter: filters, flags, gating, registers
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

// Notes on behaviour
// - Each channel has a four-bit short threshold select with sixteen settings.
// - Code n gives n steps of 45 mV, code 0 the top step; reset 2.
// - Overvoltage detection ignores the short threshold select.
// - Overvoltage sets the flag and turns both switches off.
// - Without latch, switching resumes once feedback falls below threshold minus hysteresis.
// - With latch, flag and stop hold until software writes the clear-latch bit.
// - Overcurrent sets the flag and turns both switches off.
// - Overcurrent ends by itself once the sense difference drops below the falling level.
// - Open load needs both its conditions for at least 8 consecutive cycles.
// - Open load is ignored until the soft-start ramp reaches its release level.
// - Open load sets its flag and leaves the gate drivers running.
// - Overvoltage and open-load flags are evaluated independently and may coexist.
// - Buck uses the pin as current monitor; boost drives the input disconnect.
// - When a short ends, regulation restarts through soft start.
// - Feedback below the short threshold for 8 cycles is a short.
// - In boost, sense too high or high node too low for 2 cycles is a short.
// - A short sets its flag and stops the gate drivers.
// - Feedback short detection is ignored until soft start reaches its release level.
module ofp_top
  import ofp_pkg::*;
#(
  parameter int CH_COUNT = CH_COUNT_DEF
) (
  input  wire logic                         MCLK,
  input  wire logic                         RST,
  input  wire logic [ADDR_W-1:0]            ADDR,
  input  wire logic [DATA_W-1:0]            WDATA,
  input  wire logic                         WR,
  input  wire logic                         RD,
  output logic      [DATA_W-1:0]            RDATA,
  input  wire ofp_cmp_t [CH_COUNT-1:0]      CMP,
  input  wire logic [CH_COUNT-1:0]          TOPOLOGY_SELECT,
  output logic      [CH_COUNT-1:0]          GATE_ENABLE,
  output logic      [CH_COUNT-1:0]          SOFT_START_REQ,
  output logic      [CH_COUNT*THR_W-1:0]    SHORT_TH_CODE,
  output logic      [CH_COUNT*THR_MV_W-1:0] SHORT_TH_MV,
  output logic      [CH_COUNT-1:0]          MON_CURRENT_EN,
  output logic      [CH_COUNT-1:0]          MON_DISC_O,
  output logic      [CH_COUNT-1:0]          MON_DISC_OE,
  output logic                              IRQ
);

  localparam int SYNC_W = CH_COUNT * CMP_W + CH_COUNT;
  localparam int FLT_ALL = CH_COUNT * FLT_W;

  function automatic logic [ADDR_W-1:0] cfg_addr(input int ch);
    return CFG_BASE_OFS + ADDR_W'(ch) * CFG_STRIDE;
  endfunction

  ofp_cmp_t [CH_COUNT-1:0] cmp_s;
  logic     [CH_COUNT-1:0] boost_s;
  logic     [SYNC_W-1:0]   sync_out;

  logic [THR_W-1:0]    thr_sel_reg [CH_COUNT];
  logic [CH_COUNT-1:0] ov_lat_reg;
  logic [FLT_ALL-1:0]  irq_stat_reg;
  logic [FLT_ALL-1:0]  irq_mask_reg;
  logic [FLT_ALL-1:0]  fault_vec;
  logic [FLT_ALL-1:0]  fault_prev_reg;
  logic [DATA_W-1:0]   rdata_reg;
  logic [DATA_W-1:0]   rdata_next;
  logic [CH_COUNT-1:0] clr_lat;
  logic                wr_stat;
  logic                wr_mask;
  logic                wr_ctrl;
  logic [CH_COUNT-1:0] wr_cfg;
  logic [FLT_ALL-1:0]  flt_rise;

  // Comparators and mode straps come from analog or pins
  ofp_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk  (MCLK),
    .rst  (RST),
    .din  ({TOPOLOGY_SELECT, CMP}),
    .dout (sync_out)
  );

  assign cmp_s   = sync_out[CH_COUNT*CMP_W-1:0];
  assign boost_s = sync_out[SYNC_W-1:CH_COUNT*CMP_W];

  // One strobe per register; the channel configuration strobes are decoded in the channel loop
  assign wr_stat = WR && (ADDR == IRQ_STAT_OFS);
  assign wr_mask = WR && (ADDR == IRQ_MASK_OFS);
  assign wr_ctrl = WR && (ADDR == CTRL_OFS);
  assign clr_lat = wr_ctrl ? WDATA[CH_COUNT-1:0] : '0;

  // Channel configuration
  always_ff @(posedge MCLK) begin
    if (RST) begin
      for (int c = 0; c < CH_COUNT; c++) begin
        thr_sel_reg[c] <= THR_RESET;
        ov_lat_reg[c]  <= OVLAT_RESET;
      end
    end else if (WR) begin
      for (int c = 0; c < CH_COUNT; c++) begin
        if (wr_cfg[c]) begin
          thr_sel_reg[c] <= WDATA[CFG_THR_LSB +: THR_W];
          ov_lat_reg[c]  <= WDATA[CFG_OVLAT_BIT];
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < CH_COUNT; g++) begin : g_ch
      logic                fb_short_raw;
      logic                boost_short_raw;
      logic                ol_raw;
      logic                fb_short_q;
      logic                boost_short_q;
      logic                ol_q;
      logic                short_det;
      logic                ov_reg;
      logic                oc_reg;
      logic                short_reg;
      logic                ss_req_reg;
      logic                gate_reg;
      logic                disc_reg;
      logic [THR_MV_W-1:0] th_mv_reg;

      assign fb_short_raw    = cmp_s[g].fb_below_short && cmp_s[g].ss_released;
      assign boost_short_raw = boost_s[g] && (cmp_s[g].sns_above_short || cmp_s[g].sns_high_low);
      assign ol_raw          = cmp_s[g].fb_above_ol && cmp_s[g].sns_below_ol && cmp_s[g].ss_released;

      ofp_filter #(
        .LEN (SHORT_FILT_CYC)
      ) u_fb_short (
        .clk  (MCLK),
        .rst  (RST),
        .din  (fb_short_raw),
        .dout (fb_short_q)
      );

      ofp_filter #(
        .LEN (BOOST_FILT_CYC)
      ) u_boost_short (
        .clk  (MCLK),
        .rst  (RST),
        .din  (boost_short_raw),
        .dout (boost_short_q)
      );

      ofp_filter #(
        .LEN (OL_FILT_CYC)
      ) u_open_load (
        .clk  (MCLK),
        .rst  (RST),
        .din  (ol_raw),
        .dout (ol_q)
      );

      assign short_det = fb_short_q || boost_short_q;

      // Configuration word strobe of this channel
      assign wr_cfg[g] = WR && (ADDR == cfg_addr(g));

      // Overvoltage uses its own fixed comparator, not the short threshold
      always_ff @(posedge MCLK) begin
        if (RST) begin
          ov_reg <= 1'b0;
        end else if (cmp_s[g].fb_above_ov) begin
          ov_reg <= 1'b1;
        end else if (ov_lat_reg[g]) begin
          if (clr_lat[g]) begin
            ov_reg <= 1'b0;
          end
        end else if (cmp_s[g].fb_below_ov_hys) begin
          ov_reg <= 1'b0;
        end
      end

      always_ff @(posedge MCLK) begin
        if (RST) begin
          oc_reg <= 1'b0;
        end else if (cmp_s[g].sns_above_oc_rise) begin
          oc_reg <= 1'b1;
        end else if (cmp_s[g].sns_below_oc_fall) begin
          oc_reg <= 1'b0;
        end
      end

      // Short follows the qualified condition; its end requests a soft start
      always_ff @(posedge MCLK) begin
        if (RST) begin
          short_reg  <= 1'b0;
          ss_req_reg <= 1'b0;
        end else begin
          short_reg  <= short_det;
          ss_req_reg <= short_reg && !short_det;
        end
      end

      // Open load never reaches the gate term
      always_ff @(posedge MCLK) begin
        if (RST) begin
          gate_reg <= 1'b0;
        end else begin
          gate_reg <= !(ov_reg || oc_reg || short_reg);
        end
      end

      // Drive high disconnects the input in boost while shorted
      always_ff @(posedge MCLK) begin
        if (RST) begin
          disc_reg <= 1'b0;
        end else begin
          disc_reg <= boost_s[g] && short_reg;
        end
      end

      // Registered so the threshold DAC never sees decode glitches on a write
      always_ff @(posedge MCLK) begin
        if (RST) begin
          th_mv_reg <= ofp_short_th_mv(THR_RESET);
        end else begin
          th_mv_reg <= ofp_short_th_mv(thr_sel_reg[g]);
        end
      end

      assign fault_vec[g*FLT_W + FLT_OV]    = ov_reg;
      assign fault_vec[g*FLT_W + FLT_OC]    = oc_reg;
      assign fault_vec[g*FLT_W + FLT_OL]    = ol_q;
      assign fault_vec[g*FLT_W + FLT_SHORT] = short_reg;

      assign GATE_ENABLE[g]                         = gate_reg;
      assign SOFT_START_REQ[g]                      = ss_req_reg;
      assign SHORT_TH_CODE[g*THR_W +: THR_W]        = thr_sel_reg[g];
      assign SHORT_TH_MV[g*THR_MV_W +: THR_MV_W]    = th_mv_reg;
      assign MON_CURRENT_EN[g]                      = !boost_s[g];
      assign MON_DISC_OE[g]                         = boost_s[g];
      assign MON_DISC_O[g]                          = disc_reg;
    end
  endgenerate

  // Rising edge of any fault flag is an interrupt event
  always_ff @(posedge MCLK) begin
    if (RST) begin
      fault_prev_reg <= '0;
    end else begin
      fault_prev_reg <= fault_vec;
    end
  end

  // Edges only, so a standing fault raises one event
  assign flt_rise = fault_vec & ~fault_prev_reg;

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge MCLK) begin
    if (RST) begin
      irq_stat_reg <= '0;
    end else begin
      if (wr_stat) begin
        irq_stat_reg <= (irq_stat_reg & ~WDATA[FLT_ALL-1:0]) | flt_rise;
      end else begin
        irq_stat_reg <= irq_stat_reg | flt_rise;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      irq_mask_reg <= '0;
    end else if (wr_mask) begin
      irq_mask_reg <= WDATA[FLT_ALL-1:0];
    end
  end

  assign IRQ = |(irq_stat_reg & irq_mask_reg);

  // Unmapped and write-only addresses read as zero
  always_comb begin
    rdata_next = '0;
    unique case (ADDR)
      CHANNEL_FAULT_OFS: rdata_next[FLT_ALL-1:0] = fault_vec;
      IRQ_STAT_OFS:      rdata_next[FLT_ALL-1:0] = irq_stat_reg;
      IRQ_MASK_OFS:      rdata_next[FLT_ALL-1:0] = irq_mask_reg;
      default: begin
        for (int c = 0; c < CH_COUNT; c++) begin
          if (ADDR == cfg_addr(c)) begin
            rdata_next[CFG_THR_LSB +: THR_W] = thr_sel_reg[c];
            rdata_next[CFG_OVLAT_BIT]        = ov_lat_reg[c];
          end
        end
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      rdata_reg <= '0;
    end else if (RD) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= '0;
    end
  end

  assign RDATA = rdata_reg;

endmodule

// ### verif/ofp_top_asserts.sv
// Port-level checker for the output fault protection block, channel 0
`timescale 1ns/1ps
module ofp_top_asserts
  import ofp_pkg::*;
#(
  parameter int CH_COUNT = CH_COUNT_DEF
) (
  input wire logic                         MCLK,
  input wire logic                         RST,
  input wire logic                         RD,
  input wire logic [DATA_W-1:0]            RDATA,
  input wire ofp_cmp_t [CH_COUNT-1:0]      CMP,
  input wire logic [CH_COUNT-1:0]          TOPOLOGY_SELECT,
  input wire logic [CH_COUNT-1:0]          GATE_ENABLE,
  input wire logic [CH_COUNT-1:0]          SOFT_START_REQ,
  input wire logic [CH_COUNT*THR_W-1:0]    SHORT_TH_CODE,
  input wire logic [CH_COUNT*THR_MV_W-1:0] SHORT_TH_MV,
  input wire logic [CH_COUNT-1:0]          MON_CURRENT_EN,
  input wire logic [CH_COUNT-1:0]          MON_DISC_OE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);

  // Saturating run length of a qualified feedback short; margin covers sync and flag stages
  logic [4:0] short_cnt_reg;
  always_ff @(posedge MCLK) begin
    if (RST || !(CMP[0].fb_below_short && CMP[0].ss_released)) begin
      short_cnt_reg <= 5'h00;
    end else if (short_cnt_reg != 5'h1F) begin
      short_cnt_reg <= short_cnt_reg + 5'h01;
    end
  end

  thr_decode_a: assert property (SHORT_TH_MV[9:0] == (($past(SHORT_TH_CODE[3:0]) == 4'h0) ? 10'h2D6 :
    10'($past(SHORT_TH_CODE[3:0]) * 10'h02D))) else $error("threshold decode wrong");
  ov_stop_a: assert property (CMP[0].fb_above_ov [*6] |-> !GATE_ENABLE[0])
    else $error("switching not stopped on overvoltage");
  oc_stop_a: assert property (CMP[0].sns_above_oc_rise [*6] |-> !GATE_ENABLE[0])
    else $error("switching not stopped on overcurrent");
  short_stop_a: assert property (short_cnt_reg >= 5'h0E |-> !GATE_ENABLE[0])
    else $error("switching not stopped on feedback short");
  boost_short_a: assert property ((TOPOLOGY_SELECT[0] && CMP[0].sns_above_short) [*8] |-> !GATE_ENABLE[0])
    else $error("switching not stopped on boost short");
  boost_pin_a: assert property (TOPOLOGY_SELECT[0] [*3] |-> MON_DISC_OE[0] && !MON_CURRENT_EN[0])
    else $error("monitor pin not in disconnect role");
  buck_pin_a: assert property (!TOPOLOGY_SELECT[0] [*3] |-> MON_CURRENT_EN[0] && !MON_DISC_OE[0])
    else $error("monitor pin not in current role");
  rdata_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data outside its cycle");
  ss_pulse_a: assert property (SOFT_START_REQ[0] |=> !SOFT_START_REQ[0])
    else $error("soft start request longer than one cycle");
endmodule

bind ofp_top ofp_top_asserts #(.CH_COUNT(CH_COUNT)) ofp_top_asserts_inst (.MCLK(MCLK), .RST(RST), .RD(RD),
  .RDATA(RDATA), .CMP(CMP), .TOPOLOGY_SELECT(TOPOLOGY_SELECT), .GATE_ENABLE(GATE_ENABLE),
  .SOFT_START_REQ(SOFT_START_REQ), .SHORT_TH_CODE(SHORT_TH_CODE), .SHORT_TH_MV(SHORT_TH_MV),
  .MON_CURRENT_EN(MON_CURRENT_EN), .MON_DISC_OE(MON_DISC_OE));

// ### verif/ofp_top_bench.sv
// Self-checking bench for the output fault protection block
`timescale 1ns/1ps
module ofp_top_bench
  import ofp_pkg::*;
;
  logic                 MCLK;
  logic                 RST;
  logic [ADDR_W-1:0]    ADDR;
  logic [DATA_W-1:0]    WDATA;
  logic                 WR;
  logic                 RD;
  logic [DATA_W-1:0]    RDATA;
  ofp_cmp_t [1:0]       CMP;
  logic [1:0]           TOPOLOGY_SELECT;
  logic [1:0]           GATE_ENABLE;
  logic [1:0]           SOFT_START_REQ;
  logic [7:0]           SHORT_TH_CODE;
  logic [19:0]          SHORT_TH_MV;
  logic [1:0]           MON_CURRENT_EN;
  logic [1:0]           MON_DISC_O;
  logic [1:0]           MON_DISC_OE;
  logic                 IRQ;
  int                   errors;
  int                   compares;
  logic                 seen;

  ofp_top #(.CH_COUNT(2)) ofp_top_inst (.MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .CMP(CMP), .TOPOLOGY_SELECT(TOPOLOGY_SELECT), .GATE_ENABLE(GATE_ENABLE),
    .SOFT_START_REQ(SOFT_START_REQ), .SHORT_TH_CODE(SHORT_TH_CODE), .SHORT_TH_MV(SHORT_TH_MV),
    .MON_CURRENT_EN(MON_CURRENT_EN), .MON_DISC_O(MON_DISC_O), .MON_DISC_OE(MON_DISC_OE), .IRQ(IRQ));

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Trailing delay lets the edge's updates land before sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge MCLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1;
    chk("rdata", RDATA, e);
  endtask

  // Apply channel 0 comparators, wait, then check flags and gate
  task automatic step(input logic [9:0] v, input int n, input logic [31:0] f, input logic g);
    @(posedge MCLK);
    CMP[0] <= ofp_cmp_t'(v);
    cyc(n);
    rd(CHANNEL_FAULT_OFS, f);
    chk("gate", 32'(GATE_ENABLE[0]), 32'(g));
  endtask

  task automatic end_of_test;
    $display("Compares %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    MCLK = 1'b0;
    forever #2.5 MCLK = ~MCLK;
  end

  initial begin
    repeat (4000) @(posedge MCLK);
    errors++;
    end_of_test;
  end

  initial begin
    errors = 0;
    compares = 0;
    RST = 1'b1;
    ADDR = 8'h00;
    WDATA = 32'h0;
    WR = 1'b0;
    RD = 1'b0;
    CMP = {2{ofp_cmp_t'(10'h0A1)}};
    TOPOLOGY_SELECT = 2'h0;
    repeat (3) @(posedge MCLK);
    RST <= 1'b0;
    cyc(3);
    chk("gate", 32'(GATE_ENABLE[0]), 32'h1);
    chk("gate1", 32'(GATE_ENABLE[1]), 32'h1);
    rd(CFG_BASE_OFS, 32'h2);
    rd(CFG_BASE_OFS + CFG_STRIDE, 32'h2);
    rd(CHANNEL_FAULT_OFS, 32'h0);
    rd(IRQ_MASK_OFS, 32'h0);
    rd(CTRL_OFS, 32'h0);
    rd(8'h40, 32'h0);
    for (int c = 0; c < 16; c++) begin
      wr(CFG_BASE_OFS, 32'(c));
      cyc(1);
      chk("code", 32'(SHORT_TH_CODE[3:0]), 32'(c));
      chk("mv", 32'(SHORT_TH_MV[9:0]), (c == 0) ? 32'h2D6 : 32'(32'h2D * c));
    end
    wr(CFG_BASE_OFS + CFG_STRIDE, 32'h5);
    cyc(1);
    chk("code1", 32'(SHORT_TH_CODE[7:4]), 32'h5);
    chk("mv1", 32'(SHORT_TH_MV[19:10]), 32'h0E1);
    // Overvoltage with the extreme code still trips at the fixed level
    step(10'h121, 6, 32'h1, 1'b0);
    chk("irq", 32'(IRQ), 32'h0);
    wr(IRQ_MASK_OFS, 32'h1);
    cyc(1);
    chk("irq", 32'(IRQ), 32'h1);
    rd(IRQ_MASK_OFS, 32'h1);
    rd(IRQ_STAT_OFS, 32'h1);
    wr(IRQ_STAT_OFS, 32'h1);
    cyc(1);
    chk("irq", 32'(IRQ), 32'h0);
    step(10'h0A1, 6, 32'h0, 1'b1);
    wr(CFG_BASE_OFS, 32'h12);
    step(10'h139, 14, 32'h5, 1'b0);
    step(10'h0B9, 6, 32'h5, 1'b0);
    wr(CTRL_OFS, 32'h1);
    cyc(3);
    rd(CHANNEL_FAULT_OFS, 32'h4);
    chk("gate", 32'(GATE_ENABLE[0]), 32'h1);
    step(10'h0B8, 14, 32'h0, 1'b1);
    wr(CFG_BASE_OFS, 32'h2);
    step(10'h0C1, 6, 32'h2, 1'b0);
    step(10'h0A1, 6, 32'h0, 1'b1);
    step(10'h2A0, 16, 32'h0, 1'b1);
    step(10'h2A1, 16, 32'h8, 1'b0);
    @(posedge MCLK);
    CMP[0] <= ofp_cmp_t'(10'h0A1);
    seen = 1'b0;
    repeat (12) begin
      cyc(1);
      seen = seen | (SOFT_START_REQ[0] === 1'b1);
    end
    chk("soft_start", 32'(seen), 32'h1);
    @(posedge MCLK);
    TOPOLOGY_SELECT[0] <= 1'b1;
    cyc(4);
    chk("disc_oe", 32'(MON_DISC_OE[0]), 32'h1);
    chk("cur_en", 32'(MON_CURRENT_EN[0]), 32'h0);
    step(10'h0A5, 10, 32'h8, 1'b0);
    chk("disc_o", 32'(MON_DISC_O[0]), 32'h1);
    step(10'h0A1, 6, 32'h0, 1'b1);
    step(10'h0A3, 10, 32'h8, 1'b0);
    @(posedge MCLK);
    CMP[0] <= ofp_cmp_t'(10'h0A1);
    TOPOLOGY_SELECT[0] <= 1'b0;
    cyc(4);
    chk("cur_en", 32'(MON_CURRENT_EN[0]), 32'h1);
    step(10'h0A5, 10, 32'h0, 1'b1);
    chk("disc_o", 32'(MON_DISC_O[0]), 32'h0);
    end_of_test;
  end
endmodule
